/* File: hdl/cbc_top.sv */
// Control pin logic of a configurable clock fan-out buffer with APB registers
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "cbc_defines.svh"
module cbc_top #(
  parameter int NPIN     = 4,
  parameter int NOUT     = 8,
  parameter int BANK_SZ  = 4,
  parameter int EN_CYC   = `CBC_EN_CYC,
  parameter int LOS_WIN  = `CBC_LOS_WIN
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NPIN-1:0]   upin_i,
  output logic [NPIN-1:0]        upin_o,
  output logic [NPIN-1:0]        upin_oe,
  input  wire logic              ref0_clk,
  input  wire logic              ref1_clk,
  output logic                   ref_out,
  output logic [NOUT-1:0]        out_true_en,
  output logic [NOUT-1:0]        out_comp_en,
  output logic                   irq
);
  // Registers
  logic [31:0] ctrl_r;
  logic [31:0] pincfg_r;
  logic [31:0] oemap_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;

  // Two-stage synchronisers for pins and references
  logic [NPIN-1:0] upin_s1_r, upin_s2_r;
  logic [1:0]      ref_s1_r, ref_s2_r, ref_d_r;

  // Role of pin p, two bits per pin
  function automatic cbc_pkg::cbc_role_e pin_role(input logic [31:0] cfg, input int p);
    pin_role = cbc_pkg::cbc_role_e'(cfg[2*p +: 2]);
  endfunction

  // Merge 32-bit write with byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      strb_merge[8*b +: 8] = st[b] ? wd[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // APB decode
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire hit_ctrl = (paddr == `CBC_REG_CTRL);
  wire hit_pcfg = (paddr == `CBC_REG_PINCFG);
  wire hit_oem  = (paddr == `CBC_REG_OEMAP);
  wire hit_st   = (paddr == `CBC_REG_STATUS);
  wire hit_is   = (paddr == `CBC_REG_IRQ_STAT);
  wire hit_im   = (paddr == `CBC_REG_IRQ_MASK);
  wire hit_any  = hit_ctrl | hit_pcfg | hit_oem | hit_st | hit_is | hit_im;
  assign pready  = 1'b1;
  assign pslverr = acc && !hit_any;

  // Sample pins every enabled cycle; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upin_s1_r <= '0;
      upin_s2_r <= '0;
      ref_s1_r  <= 2'h0;
      ref_s2_r  <= 2'h0;
      ref_d_r   <= 2'h0;
    end else if (clk_en) begin
      upin_s1_r <= upin_i;
      upin_s2_r <= upin_s1_r;
      ref_s1_r  <= {ref1_clk, ref0_clk};
      ref_s2_r  <= ref_s1_r;
      ref_d_r   <= ref_s2_r;
    end
  end

  // Reference select: with the CTRL two-reference bit set, any pin with select role, high chooses input 1
  logic sel_lvl;
  always_comb begin
    sel_lvl = 1'b0;
    for (int p = 0; p < NPIN; p++) begin
      if (pin_role(pincfg_r, p) == cbc_pkg::CBC_ROLE_SEL && upin_s2_r[p]) sel_lvl = 1'b1;
    end
  end
  wire use_ref1 = ctrl_r[`CBC_CTRL_TWOREF] && sel_lvl;
  // Plain mux: switching mid-cycle can chop a pulse, accepted by design
  assign ref_out = use_ref1 ? ref1_clk : ref0_clk;

  // Edge counting over a window: fewer than four edges means below minimum rate
  logic [15:0] win_r;
  logic [15:0] edg_r;
  logic        absent_r;
  logic        sel_d_r;
  wire         sel_edge = use_ref1 ? (ref_s2_r[1] & ~ref_d_r[1]) : (ref_s2_r[0] & ~ref_d_r[0]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_r    <= 16'h0000;
      edg_r    <= 16'h0000;
      absent_r <= 1'b1;
      sel_d_r  <= 1'b0;
    end else if (clk_en) begin
      sel_d_r <= use_ref1;
      if (win_r == 16'(LOS_WIN * 4 - 1)) begin
        win_r    <= 16'h0000;
        edg_r    <= 16'h0000;
        // Last cycle's edge counts too, so a reference at the minimum rate stays present
        absent_r <= ((edg_r + {15'h0000, sel_edge}) < 16'h0004);
      end else begin
        win_r <= win_r + 16'h0001;
        if (sel_edge) edg_r <= edg_r + 16'h0001;
      end
    end
  end
  // Absent flag drive with configured polarity
  wire flag_lvl = ctrl_r[`CBC_CTRL_LOSPOL] ? absent_r : ~absent_r;
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      upin_oe[p] = (pin_role(pincfg_r, p) == cbc_pkg::CBC_ROLE_ABSENT);
      upin_o[p]  = upin_oe[p] & flag_lvl;
    end
  end

  // Per-output disable request from pins: map field per pin, 0 one, 1 bank, 2 all
  logic [NOUT-1:0] dis_req;
  always_comb begin
    dis_req = '0;
    for (int p = 0; p < NPIN; p++) begin
      if (pin_role(pincfg_r, p) == cbc_pkg::CBC_ROLE_OE && upin_s2_r[p]) begin
        for (int o = 0; o < NOUT; o++) begin
          unique case (oemap_r[8*p+6 +: 2])
            2'h0:    if (o == int'(oemap_r[8*p +: 6])) dis_req[o] = 1'b1;
            2'h1:    if (o / BANK_SZ == int'(oemap_r[8*p +: 6])) dis_req[o] = 1'b1;
            default: dis_req[o] = 1'b1;
          endcase
        end
      end
    end
  end

  // One sequencer per driver keeps its true and complement pins in step
  logic [NOUT-1:0] out_en;
  for (genvar g = 0; g < NOUT; g++) begin : g_out
    cbc_out_gate #(.EN_CYC(EN_CYC)) u_gate (
      .pclk        (pclk),
      .presetn     (presetn),
      .clk_en      (clk_en),
      .disable_req (dis_req[g]),
      .out_en      (out_en[g])
    );
  end
  assign out_true_en = out_en;
  assign out_comp_en = out_en;

  // Events: flag lost, flag found, reference switched
  logic absent_d_r;
  wire [2:0] ev = {sel_d_r != use_ref1, absent_d_r & ~absent_r, ~absent_d_r & absent_r};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= `CBC_CTRL_RST;
      pincfg_r   <= `CBC_PINCFG_RST;
      oemap_r    <= `CBC_OEMAP_RST;
      irq_mask_r <= 3'h0;
      irq_stat_r <= 3'h0;
      absent_d_r <= 1'b1;
    end else if (clk_en) begin
      absent_d_r <= absent_r;
      if (wr && hit_ctrl) ctrl_r <= strb_merge(ctrl_r, pwdata, pstrb);
      if (wr && hit_pcfg) pincfg_r <= strb_merge(pincfg_r, pwdata, pstrb);
      if (wr && hit_oem) oemap_r <= strb_merge(oemap_r, pwdata, pstrb);
      if (wr && hit_im && pstrb[0]) irq_mask_r <= pwdata[2:0];
      // Set beats clear so a coincident event is kept
      irq_stat_r <= (irq_stat_r & ~((wr && hit_is && pstrb[0]) ? pwdata[2:0] : 3'h0)) | ev;
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read data registered at the setup phase
  wire [31:0] st_word = {{(24-NOUT){1'b0}}, out_en, 6'h00, use_ref1, absent_r};
  wire [31:0] rd_mux  = hit_ctrl ? ctrl_r : hit_pcfg ? pincfg_r : hit_oem ? oemap_r :
                        hit_st ? st_word : hit_is ? {29'h0, irq_stat_r} :
                        hit_im ? {29'h0, irq_mask_r} : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (clk_en && psel && !penable && !pwrite) prdata <= rd_mux;
  end
endmodule // cbc_top

/* File: hdl/cbc_defines.svh */
// Offsets, field positions, reset values and timing counts of the clock buffer control block
`ifndef CBC_DEFINES_SVH
`define CBC_DEFINES_SVH

// Register byte offsets
`define CBC_REG_CTRL      12'h000
`define CBC_REG_PINCFG    12'h004
`define CBC_REG_OEMAP     12'h008
`define CBC_REG_STATUS    12'h00C
`define CBC_REG_IRQ_STAT  12'h010
`define CBC_REG_IRQ_MASK  12'h014
`define CBC_REG_REFDIV    12'h018

// CTRL fields
`define CBC_CTRL_LOSPOL   0
`define CBC_CTRL_TWOREF   1
// STATUS fields
`define CBC_ST_ABSENT     0
`define CBC_ST_REFSEL     1
`define CBC_ST_OUTEN_LSB  8
// IRQ fields
`define CBC_IRQ_LOST      0
`define CBC_IRQ_FOUND     1
`define CBC_IRQ_REFSW     2

// Reset values
`define CBC_CTRL_RST      32'h0000_0000
`define CBC_PINCFG_RST    32'h0000_0000
`define CBC_OEMAP_RST     32'h0000_0000

// Timing
`define CBC_CLK_MHZ       100
`define CBC_EN_US         20
`define CBC_EN_CYC        (`CBC_EN_US * `CBC_CLK_MHZ - 1)
`define CBC_DIS_CYC       3
`define CBC_LOS_MIN_MHZ   10
`define CBC_LOS_WIN       (`CBC_CLK_MHZ / `CBC_LOS_MIN_MHZ)

`endif

/* File: hdl/cbc_pkg.sv */
// Types shared by the clock buffer control block
package cbc_pkg;
  // Role of a universal control pin
  typedef enum logic [1:0] {
    CBC_ROLE_NONE,
    CBC_ROLE_OE,
    CBC_ROLE_SEL,
    CBC_ROLE_ABSENT
  } cbc_role_e;

  // Per-output enable state
  typedef enum logic [1:0] {
    CBC_OUT_ON,
    CBC_OUT_STOPPING,
    CBC_OUT_OFF,
    CBC_OUT_STARTING
  } cbc_out_e;

  // Pin drive bundle: level and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } cbc_pin_drv_s;
endpackage

/* File: hdl/cbc_out_gate.sv */
// One output enable sequencer: stops within 2-6 cycles, restarts after a settle time
`timescale 1ns/100ps
`include "cbc_defines.svh"
module cbc_out_gate #(
  parameter int EN_CYC  = `CBC_EN_CYC,
  parameter int DIS_CYC = `CBC_DIS_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic disable_req,
  output logic      out_en
);
  cbc_pkg::cbc_out_e state_r;
  logic [15:0]       cnt_r;

  // Both ends of the enable sequence are counted in enabled pclk cycles
  // Start count leaves four cycles for the pin synchroniser and entry and exit edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cbc_pkg::CBC_OUT_OFF;
      cnt_r   <= 16'h0000;
    end else if (clk_en) begin
      unique case (state_r)
        cbc_pkg::CBC_OUT_ON: begin
          if (disable_req) begin
            state_r <= cbc_pkg::CBC_OUT_STOPPING;
            cnt_r   <= 16'h0000;
          end
        end
        cbc_pkg::CBC_OUT_STOPPING: begin
          if (!disable_req) begin
            state_r <= cbc_pkg::CBC_OUT_ON;
          end else if (cnt_r == 16'(DIS_CYC - 1)) begin
            state_r <= cbc_pkg::CBC_OUT_OFF;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        cbc_pkg::CBC_OUT_OFF: begin
          if (!disable_req) begin
            state_r <= cbc_pkg::CBC_OUT_STARTING;
            cnt_r   <= 16'h0000;
          end
        end
        cbc_pkg::CBC_OUT_STARTING: begin
          if (disable_req) begin
            state_r <= cbc_pkg::CBC_OUT_OFF;
          end else if (cnt_r == 16'(EN_CYC - 4)) begin
            state_r <= cbc_pkg::CBC_OUT_ON; // pin to clock within EN_CYC cycles
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
      endcase
    end
  end

  // Output is still live while stopping
  assign out_en = (state_r == cbc_pkg::CBC_OUT_ON) || (state_r == cbc_pkg::CBC_OUT_STOPPING);
endmodule // cbc_out_gate

/* File: test/cbc_top_assertions.sv */
// Port assertions for the clock buffer control block
`timescale 1ns/100ps
module cbc_top_assertions #(
  parameter int NPIN = 4,
  parameter int NOUT = 8
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [NPIN-1:0] upin_i,
  input wire logic [NPIN-1:0] upin_oe,
  input wire logic [NOUT-1:0] out_true_en,
  input wire logic [NOUT-1:0] out_comp_en,
  input wire logic            irq
);
  logic       wr;
  logic [3:0] age_r;
  logic [3:0] age_nxt;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Cycles since a controller pin was high; saturates so it never wraps
  assign wr      = psel && penable && pwrite;
  assign age_nxt = |(upin_i & ~upin_oe) ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_r <= 4'hF;
    end else begin
      age_r <= age_nxt;
    end
  end
  a_pair_en: assert property (out_true_en == out_comp_en)
    else $error("pair split");
  a_stop_cause: assert property (
    |(~out_true_en & $past(out_true_en)) |-> age_r <= 4'h7)
    else $error("stray stop");
  a_irq_clear: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
    else $error("irq dropped");
  a_role_write: assert property ($changed(upin_oe) |-> $past(wr) || $past(wr, 2))
    else $error("pin drive moved");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("stray error");
  a_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data");
  a_no_wait: assert property (psel && penable |-> pready)
    else $error("access held");
  a_start_off: assert property ($rose(presetn) |-> out_true_en == '0 && !irq)
    else $error("live at release");
  c_stop: cover property (|(~out_true_en & $past(out_true_en)));
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule // cbc_top_assertions

bind cbc_top cbc_top_assertions #(.NPIN(NPIN), .NOUT(NOUT)) i_cbc_top_assertions (.*);

/* File: test/cbc_ctl_model.sv */
// Controller model: drives the control pins and both reference clocks
`timescale 1ns/100ps
module cbc_ctl_model (
  input  wire logic [3:0] pin_lvl,
  input  wire logic [1:0] ref_run,
  input  wire logic [3:0] upin_o,
  input  wire logic [3:0] upin_oe,
  output logic [3:0]      upin_i,
  output logic            ref0_clk,
  output logic            ref1_clk
);
  // Block drive wins on its pins; other pins follow pin_lvl as the bench sets it
  assign upin_i = (upin_oe & upin_o) | (~upin_oe & pin_lvl);
  // 33 MHz references off the pclk edges; a stopped one rests low
  initial begin
    ref0_clk = 1'b0;
    ref1_clk = 1'b0;
    #1;
    // Second reference runs in anti-phase so the routed input can be told apart
    ref1_clk = ref_run[1];
    forever begin
      #15;
      ref0_clk = ref_run[0] & ~ref0_clk;
      ref1_clk = ref_run[1] & ~ref1_clk;
    end
  end
endmodule // cbc_ctl_model

/* File: test/tb.sv */
// Self-checking bench of the clock buffer control block
`timescale 1ns/100ps
module tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, irq, ref0_clk, ref1_clk, ref_out;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  upin_i, upin_o, upin_oe, pin_lvl = 4'h0;
  logic [1:0]  ref_run = 2'h3;
  logic [7:0]  out_true_en, out_comp_en, m;
  logic [65:0] exp_q[$], e;
  int          failures = 0, cmp_count = 0, n, idx;
  cbc_top i_cbc_top (.*, .clk_en(1'b1), .pstrb(4'hF));
  cbc_ctl_model i_cbc_ctl_model (.*);
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic summarize();
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One transfer; an idle edge follows so psel is never driven twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      failures++;
      summarize();
    end
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] mk, input logic [32:0] x);
    exp_q.push_back({mk, x});
    apb(1'b0, a, 32'h0);
  endtask
  // Waits for outputs (f=0) or flag pin (f=1) to reach x; sampled mid-cycle
  task automatic wt(input bit f, input logic [7:0] x, output int c);
    c = 0;
    @(negedge pclk);
    while ((f ? {7'h0, upin_o[2]} : out_true_en) !== x && c < 3000) begin
      @(negedge pclk);
      c++;
    end
    chk("wait", {25'h0, f ? {7'h0, upin_o[2]} : out_true_en}, {25'h0, x});
    if (c == 3000) begin
      summarize();
    end
    @(posedge pclk);
  endtask
  task automatic lv(input logic q);
    @(negedge pclk);
    chk("irq", {32'h0, irq}, {32'h0, q});
    // Three looks 10 ns apart span a reference half period, so both levels show
    repeat (3) begin
      chk("route", {32'h0, ref_out}, {32'h0, pin_lvl[1] ? ref1_clk : ref0_clk});
      @(negedge pclk);
    end
    @(posedge pclk);
  endtask
  // Each completed read is compared with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e = exp_q.pop_front();
      chk("read", {pslverr, prdata} & e[65:33], e[32:0]);
    end
  end
  initial begin
    void'($urandom(32'h0AF31FC1));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h004, '1, 33'h0);
    rd(12'h008, '1, 33'h0);
    rd(12'h040, '1, 33'h1_0000_0000);
    // Enable, select and flag roles on pins 0..2; start-up events cleared
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b1, 12'h004, 32'h79);
    apb(1'b1, 12'h014, 32'h7);
    repeat (100) @(posedge pclk);
    apb(1'b1, 12'h010, 32'h7);
    // Pin 0 governs one output, then a bank, then all
    for (int md = 0; md < 3; md++) begin
      idx = (md == 1) ? $urandom_range(1) : $urandom_range(7);
      m = (md == 0) ? 8'h01 << idx : (md == 1) ? 8'h0F << (idx * 4) : 8'hFF;
      apb(1'b1, 12'h008, {24'h0, 2'(md), 6'(idx)});
      wt(1'b0, 8'hFF, n);
      pin_lvl[0] <= 1'b1;
      wt(1'b0, ~m, n);
      chk("stop", 33'(n >= 2 && n <= 6), 33'h1);
      rd(12'h00C, 33'h0FF00, {17'h0, ~m, 8'h0});
      pin_lvl[0] <= 1'b0;
      wt(1'b0, 8'hFF, n);
      chk("start", 33'(n < 2000), 33'h1);
    end
    // Lose the selected reference, then move to the running one
    lv(1'b0);
    ref_run <= 2'h2;
    wt(1'b1, 8'h01, n);
    rd(12'h00C, 33'h3, 33'h1);
    lv(1'b1);
    pin_lvl[1] <= 1'b1;
    wt(1'b1, 8'h00, n);
    rd(12'h010, 33'h7, 33'h7);
    rd(12'h00C, 33'h3, 33'h2);
    lv(1'b1);
    apb(1'b1, 12'h014, 32'h0);
    lv(1'b0);
    apb(1'b1, 12'h010, 32'h7);
    rd(12'h010, 33'h7, 33'h0);
    apb(1'b1, 12'h000, 32'h2);
    wt(1'b1, 8'h01, n);
    summarize();
  end
endmodule // tb
